// File: verilog/cspsm_top.sv
// clocked serial port, synchronous mode: registers, transmitter, receiver
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// ============================================================================

module cspsm_top
  import cspsm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              serial_clock_in,
  output logic                   serial_clock_out,
  output logic                   serial_clock_oe,
  output logic                   txd,
  input  wire logic              rxd,
  output logic                   transmit_empty_irq,
  output logic                   transmit_end_irq,
  output logic                   receive_full_irq,
  output logic                   receive_error_irq
);

  // ==========================================================================
  // register state
  logic              sync_mode;
  logic [DATA_W-1:0] half_div;
  logic              clock_enable_low;
  logic              clock_enable_high;
  logic              receive_enable_bit;
  logic              transmit_enable_bit;
  logic              transmit_end_irq_enable;
  logic              receive_irq_enable;
  logic              transmit_irq_enable;
  logic [DATA_W-1:0] transmit_buffer;
  logic [DATA_W-1:0] receive_buffer;
  logic [DATA_W-1:0] transmit_shift_reg;
  logic [DATA_W-1:0] receive_shift_reg;
  logic              transmit_empty_flag;
  logic              transmit_end_flag;
  logic              receive_full_flag;
  logic              overrun_flag;
  logic              framing_error_flag;
  logic              parity_error_flag;
  logic [DATA_W-1:0] serial_status_reg;

  // engine state
  logic              rxd_meta;
  logic              rxd_sync;
  logic              tx_busy;
  logic [3:0]        tx_left;
  logic              rx_busy;
  logic [2:0]        rx_cnt;
  logic              fall_evt;
  logic              rise_evt;

  // decoded strobes and engine terms
  logic              wr_mode;
  logic              wr_baud;
  logic              wr_ctrl;
  logic              wr_txbuf;
  logic              wr_stat;
  logic              rd_rxbuf;
  logic              rx_err;
  logic              int_mode;
  logic              tx_on;
  logic              tx_start;
  logic              tx_bit7;
  logic              tx_more;
  logic              tx_reload;
  logic              tx_last;
  logic              tx_load;
  logic [DATA_W-1:0] tx_load_data;
  logic              rx_go;
  logic              rx_start_ok;
  logic              rx_cont_ok;
  logic              rx_done;
  logic              rx_store;
  logic [DATA_W-1:0] rx_new;

  // ==========================================================================
  // address decode
  assign wr_mode  = reg_write && (reg_addr == OFS_MODE);
  assign wr_baud  = reg_write && (reg_addr == OFS_BAUD);
  assign wr_ctrl  = reg_write && (reg_addr == OFS_CTRL);
  assign wr_txbuf = reg_write && (reg_addr == OFS_TXBUF);
  assign wr_stat  = reg_write && (reg_addr == OFS_STAT);
  assign rd_rxbuf = reg_read && (reg_addr == OFS_RXBUF);

  // mode, divider and control bits
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_mode               <= MODE_RST[MODE_SYNC];
      half_div                <= BAUD_RST;
      clock_enable_low        <= CTRL_RST[CTRL_CKE_LOW];
      clock_enable_high       <= CTRL_RST[CTRL_CKE_HIGH];
      receive_enable_bit      <= CTRL_RST[CTRL_RX_EN];
      transmit_enable_bit     <= CTRL_RST[CTRL_TX_EN];
      transmit_end_irq_enable <= CTRL_RST[CTRL_TRANSMIT_END_FLAG_IE];
      receive_irq_enable      <= CTRL_RST[CTRL_RX_IE];
      transmit_irq_enable     <= CTRL_RST[CTRL_TX_IE];
    end
    else
    begin
      if (wr_mode)
        sync_mode <= reg_wdata[MODE_SYNC];
      if (wr_baud)
        half_div <= reg_wdata;
      // one write sets both enables together for duplex start
      if (wr_ctrl)
      begin
        clock_enable_low        <= reg_wdata[CTRL_CKE_LOW];
        clock_enable_high       <= reg_wdata[CTRL_CKE_HIGH];
        receive_enable_bit      <= reg_wdata[CTRL_RX_EN];
        transmit_enable_bit     <= reg_wdata[CTRL_TX_EN];
        transmit_end_irq_enable <= reg_wdata[CTRL_TRANSMIT_END_FLAG_IE];
        receive_irq_enable      <= reg_wdata[CTRL_RX_IE];
        transmit_irq_enable     <= reg_wdata[CTRL_TX_IE];
      end
    end
  end

  // transmit holding buffer, written at any time
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      transmit_buffer <= 8'h00;
    else if (wr_txbuf)
      transmit_buffer <= reg_wdata;
  end

  always_comb
  begin
    serial_status_reg            = 8'h00;
    serial_status_reg[STAT_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag;
    serial_status_reg[STAT_RECEIVE_FULL_FLAG] = receive_full_flag;
    serial_status_reg[STAT_OER]  = overrun_flag;
    serial_status_reg[STAT_FER]  = framing_error_flag;
    serial_status_reg[STAT_PER]  = parity_error_flag;
    serial_status_reg[STAT_TRANSMIT_END_FLAG] = transmit_end_flag;
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (!reg_read)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        OFS_MODE:  reg_rdata <= {7'h00, sync_mode};
        OFS_BAUD:  reg_rdata <= half_div;
        OFS_CTRL:  reg_rdata <= {1'b0, transmit_irq_enable, receive_irq_enable,
                                 transmit_end_irq_enable, transmit_enable_bit,
                                 receive_enable_bit, clock_enable_high,
                                 clock_enable_low};
        OFS_TXBUF: reg_rdata <= transmit_buffer;
        OFS_STAT:  reg_rdata <= serial_status_reg;
        OFS_RXBUF: reg_rdata <= receive_buffer;
        default:   reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // clock selection: high enable picks the external pin, else divider drives out
  assign int_mode = sync_mode && !clock_enable_high;

  cspsm_clk_src u_clk_src (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .ext_sel  (clock_enable_high),
    .run      (tx_busy || rx_busy),
    .half_div (half_div),
    .sck_in   (serial_clock_in),
    .sck_out  (serial_clock_out),
    .fall_evt (fall_evt),
    .rise_evt (rise_evt)
  );

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      serial_clock_oe <= 1'b0;
    else
      serial_clock_oe <= int_mode;
  end

  // receive pin crosses into clk_sys through two flops
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // ==========================================================================
  // transmitter
  assign rx_err   = overrun_flag || framing_error_flag || parity_error_flag;
  assign tx_on    = transmit_enable_bit && sync_mode;
  assign tx_start = tx_on && !tx_busy && !transmit_empty_flag && !rx_err;
  assign tx_bit7  = tx_on && fall_evt && tx_busy && (tx_left == LAST_LEFT);
  assign tx_more  = !transmit_empty_flag && !rx_err;
  assign tx_reload = tx_bit7 && tx_more;
  assign tx_last   = tx_bit7 && !tx_more;
  assign tx_load   = tx_start || tx_reload;
  // a write landing on a load is taken straight into the shifter, not lost
  assign tx_load_data = wr_txbuf ? reg_wdata : transmit_buffer;

  // shift out lsb first on falling edges; frame ends on the eighth rise
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_busy            <= 1'b0;
      tx_left            <= 4'h0;
      transmit_shift_reg <= 8'h00;
      txd                <= 1'b1;
    end
    else if (!tx_on)
    begin
      tx_busy <= 1'b0;
      tx_left <= 4'h0;
      txd     <= 1'b1;
    end
    else if (tx_start)
    begin
      tx_busy            <= 1'b1;
      tx_left            <= FRAME_BITS;
      transmit_shift_reg <= tx_load_data;
    end
    else if (fall_evt && tx_busy && (tx_left != 4'h0))
    begin
      txd <= transmit_shift_reg[0];
      if (tx_reload)
      begin
        transmit_shift_reg <= tx_load_data;
        tx_left            <= FRAME_BITS;
      end
      else
      begin
        transmit_shift_reg <= {1'b0, transmit_shift_reg[DATA_W-1:1]};
        tx_left            <= tx_left - 4'h1;
      end
    end
    else if (rise_evt && tx_busy && (tx_left == 4'h0))
      tx_busy <= 1'b0;
  end

  // empty flag: hardware set wins over the write that clears it
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      transmit_empty_flag <= 1'b1;
    else if (!transmit_enable_bit)
      transmit_empty_flag <= 1'b1;
    else if (tx_load)
      transmit_empty_flag <= 1'b1;
    else if (wr_txbuf)
      transmit_empty_flag <= 1'b0;
  end

  // end flag: set when the eighth bit goes out without a reload, or on disable; start or write clears it
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      transmit_end_flag <= 1'b1;
    else if (tx_last || !transmit_enable_bit)
      transmit_end_flag <= 1'b1;
    else if (tx_start || wr_txbuf)
      transmit_end_flag <= 1'b0;
  end

  // ==========================================================================
  // receiver; in internal mode with both sides on, frames stay aligned
  assign rx_go       = receive_enable_bit && sync_mode && !rx_err;
  assign rx_start_ok = !int_mode || !transmit_enable_bit || tx_start;
  assign rx_cont_ok  = !int_mode || !transmit_enable_bit ||
                       (tx_busy && (tx_left == FRAME_BITS));
  assign rx_new      = {rxd_sync, receive_shift_reg[DATA_W-1:1]};
  assign rx_done     = rx_go && rise_evt && rx_busy && (rx_cnt == LAST_BIT);
  assign rx_store    = rx_done && !receive_full_flag;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_busy           <= 1'b0;
      rx_cnt            <= 3'h0;
      receive_shift_reg <= 8'h00;
    end
    else if (!rx_go)
    begin
      rx_busy <= 1'b0;
      rx_cnt  <= 3'h0;
    end
    else if (!rx_busy)
    begin
      rx_busy <= rx_start_ok;
      rx_cnt  <= 3'h0;
    end
    else if (rise_evt)
    begin
      receive_shift_reg <= rx_new;
      rx_cnt            <= rx_cnt + 3'h1;
      if (rx_cnt == LAST_BIT)
        rx_busy <= rx_cont_ok;
    end
  end

  // receive buffer and flags; enable bit never touches them
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      receive_buffer <= 8'h00;
    else if (rx_store)
      receive_buffer <= rx_new;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      receive_full_flag <= 1'b0;
    else if (rx_store)
      receive_full_flag <= 1'b1;
    else if (rd_rxbuf || (wr_stat && !reg_wdata[STAT_RECEIVE_FULL_FLAG]))
      receive_full_flag <= 1'b0;
  end

  // error flags clear only by writing zero; overrun set wins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      overrun_flag       <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
    end
    else
    begin
      if (rx_done && receive_full_flag)
        overrun_flag <= 1'b1;
      else if (wr_stat && !reg_wdata[STAT_OER])
        overrun_flag <= 1'b0;
      // no framing or parity check exists here; software may only clear
      if (wr_stat && !reg_wdata[STAT_FER])
        framing_error_flag <= 1'b0;
      if (wr_stat && !reg_wdata[STAT_PER])
        parity_error_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupt request levels
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      transmit_empty_irq <= 1'b0;
      transmit_end_irq   <= 1'b0;
      receive_full_irq   <= 1'b0;
      receive_error_irq  <= 1'b0;
    end
    else
    begin
      transmit_empty_irq <= transmit_empty_flag && transmit_irq_enable;
      transmit_end_irq   <= transmit_end_flag && transmit_end_irq_enable;
      receive_full_irq   <= receive_full_flag && receive_irq_enable;
      receive_error_irq  <= rx_err && receive_irq_enable;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_transmit_empty_flag_on_load: assert property (tx_start |=> transmit_empty_flag && tx_busy)
    else $error("load did not set empty flag");
  a_txi_after_load: assert property (tx_start && transmit_irq_enable ##1 transmit_irq_enable
    |=> transmit_empty_irq)
    else $error("empty request missing after load");
  a_tx_lsb_first: assert property (fall_evt && tx_on && tx_busy && (tx_left == FRAME_BITS)
    |=> txd == $past(transmit_shift_reg[0]))
    else $error("first bit not lsb");
  a_txd_on_fall: assert property ($changed(txd) |-> $past(fall_evt) || !$past(tx_on))
    else $error("transmit line moved off a falling edge");
  a_hold_last_bit: assert property (transmit_end_flag && tx_on && !tx_start
    |=> $stable(txd))
    else $error("line did not hold last bit");
  a_no_tx_on_err: assert property (rx_err |-> !tx_start && !tx_reload)
    else $error("transmit began with error flag set");
  a_overrun_keeps: assert property (rx_done && receive_full_flag
    |=> overrun_flag && receive_full_flag && $stable(receive_buffer))
    else $error("overrun handling wrong");
  a_rx_store: assert property (rx_store |=> receive_full_flag
    && (receive_buffer == $past(rx_new)))
    else $error("received byte not stored");
  a_rx_halted: assert property (rx_err |=> !rx_busy)
    else $error("receiver runs with error flag set");
  a_read_clears: assert property (rd_rxbuf && !rx_store |=> !receive_full_flag)
    else $error("read did not clear full flag");
  a_write_clears: assert property (wr_txbuf && transmit_enable_bit && !tx_load
    |=> !transmit_empty_flag)
    else $error("write did not clear empty flag");
  a_te_off_empty: assert property (!transmit_enable_bit |=> transmit_empty_flag)
    else $error("empty flag not forced by disable");
  a_sck_idle_high: assert property (int_mode && !tx_busy && !rx_busy
    ##1 !tx_busy && !rx_busy |-> serial_clock_out)
    else $error("clock not resting high");

  c_tx_reload: cover property (tx_reload);
  c_tx_end:    cover property (tx_last);
  c_rx_store:  cover property (rx_store);
  c_overrun:   cover property (rx_done && receive_full_flag);

endmodule

`default_nettype wire

// File: verilog/cspsm_pkg.sv
// constants shared by the clocked serial port in synchronous mode
package cspsm_pkg;

  // ==========================================================================
  // register port
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_MODE  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_BAUD  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_TXBUF = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_RXBUF = 5'h14;

  // ==========================================================================
  // field positions
  localparam int MODE_SYNC     = 0;
  localparam int CTRL_CKE_LOW  = 0;
  localparam int CTRL_CKE_HIGH = 1;
  localparam int CTRL_RX_EN    = 2;
  localparam int CTRL_TX_EN    = 3;
  localparam int CTRL_TRANSMIT_END_FLAG_IE  = 4;
  localparam int CTRL_RX_IE    = 5;
  localparam int CTRL_TX_IE    = 6;
  localparam int STAT_TRANSMIT_END_FLAG     = 2;
  localparam int STAT_PER      = 3;
  localparam int STAT_FER      = 4;
  localparam int STAT_OER      = 5;
  localparam int STAT_RECEIVE_FULL_FLAG     = 6;
  localparam int STAT_TRANSMIT_EMPTY_FLAG     = 7;

  // ==========================================================================
  // reset values and frame shape
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [DATA_W-1:0] BAUD_RST = 8'h03;
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [3:0]        FRAME_BITS = 4'h8;
  localparam logic [3:0]        LAST_LEFT  = 4'h1;
  localparam logic [2:0]        LAST_BIT   = 3'h7;

endpackage

// File: verilog/cspsm_clk_src.sv
// serial clock source: internal divider or synchronised external clock edges
`timescale 1ns/100ps
`default_nettype none

module cspsm_clk_src
  import cspsm_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              ext_sel,
  input  wire logic              run,
  input  wire logic [DATA_W-1:0] half_div,
  input  wire logic              sck_in,
  output logic                   sck_out,
  output logic                   fall_evt,
  output logic                   rise_evt
);

  logic              sck_meta;
  logic              sck_sync;
  logic              sck_prev;
  logic [DATA_W-1:0] div_cnt;
  logic              div_hit;

  assign div_hit = (div_cnt == half_div);

  // ==========================================================================
  // external clock: two flops, then a third for edge finding
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_meta <= 1'b1;
      sck_sync <= 1'b1;
      sck_prev <= 1'b1;
    end
    else
    begin
      sck_meta <= sck_in;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
    end
  end

  // ==========================================================================
  // internal clock: toggles every half_div+1 cycles, rests high when idle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_cnt <= 8'h00;
      sck_out <= 1'b1;
    end
    else if (!run || ext_sel)
    begin
      div_cnt <= 8'h00;
      sck_out <= 1'b1;
    end
    else if (div_hit)
    begin
      div_cnt <= 8'h00;
      sck_out <= !sck_out;
    end
    else
      div_cnt <= div_cnt + 8'h01;
  end

  // edge pulses, one cycle each, from whichever source is selected
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fall_evt <= 1'b0;
      rise_evt <= 1'b0;
    end
    else if (ext_sel)
    begin
      fall_evt <= sck_prev && !sck_sync;
      rise_evt <= !sck_prev && sck_sync;
    end
    else
    begin
      fall_evt <= run && div_hit && sck_out;
      rise_evt <= run && div_hit && !sck_out;
    end
  end

endmodule

`default_nettype wire

// File: testbench/cspsm_peer.sv
// far-side peer sharing the serial clock
`timescale 1ns/100ps
`default_nettype none
module cspsm_peer
#(
  parameter logic [7:0] PATTERN = 8'ha5
)
(
  input  wire logic       sck,
  input  wire logic       txd,
  output logic            rxd,
  output logic      [7:0] captured
);
  // ==========================================================================
  // peer shifters
  logic [15:0] shr;
  initial
  begin
    shr = {~PATTERN, PATTERN};
    rxd = 1'b1;
    captured = 8'h00;
  end
  // new bit on each fall; frames alternate pattern and inverse, so a lost byte shows
  always @(negedge sck)
  begin
    rxd <= shr[0];
    shr <= {shr[0], shr[15:1]};
  end
  // device data taken on the rise, lsb arrives first
  always @(posedge sck)
    captured <= {txd, captured[7:1]};
endmodule
`default_nettype wire

// File: testbench/tb_cspsm_top.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none
module tb_cspsm_top
  import cspsm_pkg::*;
;
  // ==========================================================================
  // signals
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 5'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              sck_out, sck_oe, sck_pin, txd, rxd;
  logic              irq_te, irq_transmit_end_flag, irq_rf, irq_re;
  logic [7:0]        captured, s;
  logic              sck_ext = 1'b1;
  int                num_errors = 0;
  int                cmp_count = 0;
  int                falls = 0;
  always #4 clk_sys = ~clk_sys;
  // external clock model drives the pin when the device does not; idle high
  assign sck_pin = sck_oe ? sck_out : sck_ext;
  always @(negedge sck_out) falls++;
  cspsm_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .serial_clock_in(sck_pin), .serial_clock_out(sck_out), .serial_clock_oe(sck_oe),
    .txd(txd), .rxd(rxd), .transmit_empty_irq(irq_te), .transmit_end_irq(irq_transmit_end_flag),
    .receive_full_irq(irq_rf), .receive_error_irq(irq_re));
  cspsm_peer u_peer (.sck(sck_pin), .txd(txd), .rxd(rxd), .captured(captured));
  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 s = reg_rdata;
  endtask
  task automatic poll(input logic [7:0] mask);
    for (int i = 0; i < 400; i++)
    begin
      rd(OFS_STAT);
      if ((s & mask) === mask)
        return;
    end
    chk("poll", s & mask, mask);
    stop_test();
  endtask
  task automatic wait_falls(input int n);
    for (int i = 0; i < 2000; i++)
    begin
      if (falls >= n)
        return;
      @(posedge clk_sys);
    end
    chk("falls", falls[7:0], n[7:0]);
    stop_test();
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_single();
    chk("stat", s, 8'h84);
    rd(5'h1c);
    chk("unmapped", s, 8'h00);
    wr(OFS_MODE, 8'h01);
    wr(OFS_BAUD, 8'h04); // 80 ns serial clock
    wr(OFS_CTRL, 8'h7c);
    wr(OFS_TXBUF, 8'h3c);
    poll(8'h40);
    chk("peer", captured, 8'h3c);
    chk("pulses", falls[7:0], 8'h08);
    chk("msb hold", {7'h0, txd}, 8'h00);
    chk("rx pin", {7'h0, rxd}, 8'h01);
    chk("sck", {6'h0, sck_out, sck_oe}, 8'h03);
    rd(OFS_STAT);
    chk("stat", s, 8'hc4);
    chk("irq", {irq_te, irq_transmit_end_flag, irq_rf, irq_re, 4'h0}, 8'he0);
    rd(OFS_RXBUF);
    chk("rx", s, 8'ha5);
    rd(OFS_STAT);
    chk("stat", s, 8'h84);
    $display("single frame done");
  endtask
  task automatic t_overrun();
    falls = 0;
    wr(OFS_TXBUF, 8'h81);
    poll(8'h80);
    wr(OFS_TXBUF, 8'h42);
    poll(8'h20);
    chk("peer", captured, 8'h42);
    chk("pulses", falls[7:0], 8'h10);
    rd(OFS_STAT);
    chk("stat", s, 8'he4);
    chk("err irq", {7'h0, irq_re}, 8'h01);
    rd(OFS_RXBUF);
    chk("kept", s, 8'h5a);
    $display("overrun done");
  endtask
  task automatic t_blocked();
    falls = 0;
    wr(OFS_CTRL, 8'h78);
    wr(OFS_TXBUF, 8'h55);
    repeat (100) @(posedge clk_sys);
    chk("no start", falls[7:0], 8'h00);
    rd(OFS_STAT);
    chk("stat", s, 8'h20);
    wr(OFS_STAT, 8'h00);
    rd(OFS_STAT);
    chk("flags", s & 8'h78, 8'h00);
    wait_falls(8);
    repeat (12) @(posedge clk_sys); // last half period plus sync delay
    chk("peer", captured, 8'h55);
    $display("blocked start done");
  endtask
  task automatic t_disable();
    falls = 0;
    wr(OFS_TXBUF, 8'hff);
    wait_falls(2);
    wr(OFS_TXBUF, 8'h11);
    rd(OFS_STAT);
    chk("empty", s & 8'h80, 8'h00);
    wr(OFS_CTRL, 8'h00);
    rd(OFS_STAT);
    chk("stat", s, 8'h84);
    chk("lines", {6'h0, txd, sck_out}, 8'h03);
    $display("disable done");
  endtask
  // external clock at 80 ns, stands high outside the frame
  task automatic t_external();
    wr(OFS_CTRL, 8'h0a);
    wr(OFS_TXBUF, 8'h69);
    for (int i = 0; i < 8; i++)
    begin
      repeat (5) @(posedge clk_sys);
      sck_ext <= 1'b0;
      repeat (5) @(posedge clk_sys);
      sck_ext <= 1'b1;
    end
    repeat (8) @(posedge clk_sys); // edges reach the engine three cycles late
    chk("ext peer", captured, 8'h69);
    chk("ext lines", {6'h0, txd, sck_oe}, 8'h00);
    rd(OFS_STAT);
    chk("ext stat", s, 8'h84);
    $display("external clock done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(OFS_STAT);
    t_single();
    t_overrun();
    t_blocked();
    t_disable();
    t_external();
    stop_test();
  end
endmodule
`default_nettype wire
